// *** core/camtp_core.sv ***
// Purpose: CAN acceptance mask, mailbox data window and message timer prescaler
// Assumes: register access and filter inputs come from logic on CLK_I
// Notes: mask and mailbox storage carry no reset and read undefined until written
`timescale 1ns/100ps
`default_nettype none

// Contract
// - mask three/four hold identifier bits 12..0
// - mask bit one compares, zero forces true
// - fourth register bit 2 masks remote request
// - fourth register bit 0 masks format bit
// - mask used only for receiving objects
// - bit 1 reserved, software writes zero
// - mask registers not initialised by reset
// - data register accesses selected mailbox byte
// - 8-bit prescaler register, resets to zero
// - first two registers hold bits 28..13
// - 16-bit read-only timer, high/low bytes
module camtp_core (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  output logic [7:0] SFR_RDATA_O,
  input wire logic [camtp_pkg::OBJ_W-1:0] OBJ_SEL_I,
  input wire logic AUTO_INC_I,
  input wire logic PTR_LOAD_I,
  input wire logic [camtp_pkg::PTR_W-1:0] PTR_INDEX_I,
  input wire logic [camtp_pkg::ID_W-1:0] RX_ID_I,
  input wire logic RX_RTR_I,
  input wire logic RX_IDE_I,
  input wire logic [camtp_pkg::ID_W-1:0] TAG_ID_I,
  input wire logic TAG_RTR_I,
  input wire logic TAG_IDE_I,
  input wire logic OBJ_IS_RX_I,
  output logic ACCEPT_HIT_O
);
  import camtp_pkg::*;

  logic [7:0] mask_one;
  logic [7:0] mask_two;
  logic [7:0] mask_three;
  logic [7:0] mask_four;
  logic [7:0] prescale;
  logic [7:0] presc_cnt;
  logic [15:0] timer;
  logic [PTR_W-1:0] ptr;
  logic [7:0] mbox [MBOX_DEPTH];

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  wire wr_prescale = SFR_WR_I && (SFR_ADDR_I == ADDR_PRESCALE);
  wire wr_mbox = SFR_WR_I && (SFR_ADDR_I == ADDR_MBOX_DATA);
  wire rd_mbox = SFR_RD_I && (SFR_ADDR_I == ADDR_MBOX_DATA);
  wire wr_mask_one = SFR_WR_I && (SFR_ADDR_I == ADDR_MASK_ONE);
  wire wr_mask_two = SFR_WR_I && (SFR_ADDR_I == ADDR_MASK_TWO);
  wire wr_mask_three = SFR_WR_I && (SFR_ADDR_I == ADDR_MASK_THREE);
  wire wr_mask_four = SFR_WR_I && (SFR_ADDR_I == ADDR_MASK_FOUR);
  wire mbox_access = wr_mbox || rd_mbox;
  wire [OBJ_W+PTR_W-1:0] mbox_idx = {OBJ_SEL_I, ptr};

  // --------------------------------------------------------------
  // acceptance compare
  // --------------------------------------------------------------
  wire [ID_W-1:0] id_mask = {mask_one, mask_two, mask_three,
                             mask_four[MASK4_ID_HI:MASK4_ID_LO]};
  wire [ID_W-1:0] id_match = ~((RX_ID_I ^ TAG_ID_I) & id_mask);
  wire rtr_match = !(mask_four[MASK4_RTR_BIT] && (RX_RTR_I != TAG_RTR_I));
  wire ide_match = !(mask_four[MASK4_IDE_BIT] && (RX_IDE_I != TAG_IDE_I));
  wire next_hit = OBJ_IS_RX_I && (&id_match) && rtr_match && ide_match;

  // --------------------------------------------------------------
  // prescaler, timer and mailbox pointer
  // --------------------------------------------------------------
  wire tick = (presc_cnt == prescale);
  wire [7:0] next_presc_cnt = tick ? READ_ZERO : presc_cnt + 8'h01;
  wire [15:0] next_timer = tick ? timer + 16'h0001 : timer;
  wire [PTR_W-1:0] next_ptr = PTR_LOAD_I ? PTR_INDEX_I :
      (mbox_access && AUTO_INC_I) ? ptr + 3'h1 : ptr;

  // --------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    unique case (SFR_ADDR_I)
      ADDR_PRESCALE: rd_mux = prescale;
      ADDR_MBOX_DATA: rd_mux = mbox[mbox_idx];
      ADDR_TIMER_LOW: rd_mux = timer[7:0];
      ADDR_TIMER_HIGH: rd_mux = timer[15:8];
      ADDR_MASK_ONE: rd_mux = mask_one;
      ADDR_MASK_TWO: rd_mux = mask_two;
      ADDR_MASK_THREE: rd_mux = mask_three;
      // reserved bit reads as zero
      ADDR_MASK_FOUR: rd_mux = {mask_four[7:2], 1'b0, mask_four[0]};
      default: rd_mux = READ_ZERO;
    endcase
  end

  // --------------------------------------------------------------
  // storage without reset
  // --------------------------------------------------------------
  // masks and mailbox are undefined until software writes them
  always_ff @(posedge CLK_I) begin
    if (wr_mask_one) mask_one <= SFR_WDATA_I;
    if (wr_mask_two) mask_two <= SFR_WDATA_I;
    if (wr_mask_three) mask_three <= SFR_WDATA_I;
    if (wr_mask_four) mask_four <= SFR_WDATA_I;
    if (wr_mbox) mbox[mbox_idx] <= SFR_WDATA_I;
  end

  // --------------------------------------------------------------
  // control state with reset
  // --------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      prescale <= PRESCALE_RST;
      presc_cnt <= READ_ZERO;
      timer <= TIMER_RST;
      ptr <= '0;
      SFR_RDATA_O <= READ_ZERO;
      ACCEPT_HIT_O <= 1'b0;
    end else begin
      if (wr_prescale) prescale <= SFR_WDATA_I;
      presc_cnt <= next_presc_cnt;
      timer <= next_timer;
      ptr <= next_ptr;
      if (SFR_RD_I) SFR_RDATA_O <= rd_mux;
      ACCEPT_HIT_O <= next_hit;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  logic [8:0] since_tick;
  logic presc_dirty;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      since_tick <= 9'h000;
      presc_dirty <= 1'b0;
    end else begin
      since_tick <= tick ? 9'h000 : since_tick + 9'h001;
      presc_dirty <= wr_prescale || (presc_dirty && !tick);
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  mask_open_accept_a: assert property (
    (OBJ_IS_RX_I && id_mask == '0 && !mask_four[MASK4_RTR_BIT] &&
     !mask_four[MASK4_IDE_BIT]) |=> ACCEPT_HIT_O)
    else $error("open mask did not accept");
  id_bit_reject_a: assert property (
    (id_mask[0] && RX_ID_I[0] != TAG_ID_I[0]) |=> !ACCEPT_HIT_O)
    else $error("enabled id bit mismatch accepted");
  rtr_mask_a: assert property (
    (mask_four[MASK4_RTR_BIT] && RX_RTR_I != TAG_RTR_I) |=> !ACCEPT_HIT_O)
    else $error("remote request mismatch accepted");
  ide_mask_a: assert property (
    (mask_four[MASK4_IDE_BIT] && RX_IDE_I != TAG_IDE_I) |=> !ACCEPT_HIT_O)
    else $error("format mismatch accepted");
  tx_no_hit_a: assert property (
    !OBJ_IS_RX_I |=> !ACCEPT_HIT_O)
    else $error("transmit object accepted");
  rsvd_read_a: assert property (
    (SFR_RD_I && SFR_ADDR_I == ADDR_MASK_FOUR) |=> !SFR_RDATA_O[MASK4_RSVD_BIT])
    else $error("reserved bit read nonzero");
  mask_three_map_a: assert property (
    wr_mask_three |=> id_mask[12:5] == $past(SFR_WDATA_I))
    else $error("mask three misplaced");
  timer_step_a: assert property (
    tick |=> timer == $past(timer) + 16'h0001)
    else $error("timer did not step on tick");
  timer_hold_a: assert property (
    !tick |=> $stable(timer))
    else $error("timer moved without tick");
  tick_period_a: assert property (
    (tick && !presc_dirty && since_tick != 9'h000) |->
      since_tick == {1'b0, prescale})
    else $error("tick period wrong");
  presc_read_a: assert property (
    (wr_prescale ##1 (SFR_RD_I && SFR_ADDR_I == ADDR_PRESCALE && !wr_prescale))
      |=> SFR_RDATA_O == $past(SFR_WDATA_I, 2))
    else $error("prescaler readback wrong");
  ptr_wrap_a: assert property (
    (mbox_access && AUTO_INC_I && !PTR_LOAD_I) |=> ptr == $past(ptr) + 3'h1)
    else $error("pointer did not advance");
  mbox_rw_a: assert property (
    (wr_mbox && !AUTO_INC_I && !PTR_LOAD_I) ##1
      (rd_mbox && $stable(OBJ_SEL_I) && !wr_mbox) |=> SFR_RDATA_O == $past(SFR_WDATA_I, 2))
    else $error("mailbox readback wrong");

  hit_cov: cover property (OBJ_IS_RX_I ##1 ACCEPT_HIT_O);
  tick_cov: cover property (tick && prescale == 8'h03);
  wrap_cov: cover property (mbox_access && AUTO_INC_I && ptr == 3'h7);
  rtr_cov: cover property (mask_four[MASK4_RTR_BIT] && RX_RTR_I != TAG_RTR_I);
endmodule : camtp_core

`default_nettype wire

// *** shared/camtp_pkg.sv ***
// Purpose: constants for the acceptance mask, mailbox window and timer prescaler
// Assumes: 8-bit special function register bus, one system clock
// Notes: offsets are the byte addresses of the register space
package camtp_pkg;
  // --------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_PRESCALE = 8'hA1;
  localparam logic [7:0] ADDR_MBOX_DATA = 8'hA3;
  localparam logic [7:0] ADDR_TIMER_LOW = 8'hAC;
  localparam logic [7:0] ADDR_TIMER_HIGH = 8'hAD;
  localparam logic [7:0] ADDR_MASK_ONE = 8'hC4;
  localparam logic [7:0] ADDR_MASK_TWO = 8'hC5;
  localparam logic [7:0] ADDR_MASK_THREE = 8'hC6;
  localparam logic [7:0] ADDR_MASK_FOUR = 8'hC7;
  // --------------------------------------------------------------
  // field layout of the fourth mask register
  // --------------------------------------------------------------
  localparam int MASK4_ID_HI = 7;
  localparam int MASK4_ID_LO = 3;
  localparam int MASK4_RTR_BIT = 2;
  localparam int MASK4_RSVD_BIT = 1;
  localparam int MASK4_IDE_BIT = 0;
  // --------------------------------------------------------------
  // sizes and reset values
  // --------------------------------------------------------------
  localparam int ID_W = 29;
  localparam int OBJ_W = 2;
  localparam int PTR_W = 3;
  localparam int MBOX_DEPTH = 32;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [7:0] READ_ZERO = 8'h00;
endpackage : camtp_pkg

// *** verification/camtp_rx_node.sv ***
// Purpose: remote node model, supplies received frame fields
// Assumes: one new frame per step pulse
// Notes: fields change only just after a clock edge
`timescale 1ns/100ps
`default_nettype none
module camtp_rx_node (
  input wire logic clk_i,
  input wire logic step_i,
  output logic [28:0] id_o,
  output logic rtr_o,
  output logic ide_o
);
  initial {id_o, rtr_o, ide_o} = '0;
  always @(posedge clk_i) begin
    if (step_i) begin
      id_o <= 29'($urandom);
      rtr_o <= 1'($urandom);
      ide_o <= 1'($urandom);
    end
  end
endmodule : camtp_rx_node
`default_nettype wire

// *** verification/can_accept_mask_msg_timer_presc_tb.sv ***
// Purpose: self-checking bench for mask, mailbox window and prescaler
// Assumes: masks and mailbox are written before use
// Notes: tags differ from frames by at most one bit to stress the masks
`timescale 1ns/100ps
`default_nettype none
module can_accept_mask_msg_timer_presc_tb;
  import camtp_pkg::*;
  logic CLK_I = 0, RESET_N_I = 0, SFR_WR_I = 0, SFR_RD_I = 0, AUTO_INC_I = 0;
  logic PTR_LOAD_I = 0, TAG_RTR_I = 0, TAG_IDE_I = 0, OBJ_IS_RX_I = 0, step = 0;
  logic [7:0] SFR_ADDR_I = 0, SFR_WDATA_I = 0, v, t0;
  logic [1:0] OBJ_SEL_I = 0;
  logic [2:0] PTR_INDEX_I = 0;
  logic [28:0] TAG_ID_I = 0, mk;
  logic [7:0] m [4];
  wire logic [7:0] SFR_RDATA_O;
  wire logic [28:0] RX_ID_I;
  wire logic RX_RTR_I, RX_IDE_I, ACCEPT_HIT_O;
  int err_count = 0, compares = 0, b;
  always #5 CLK_I = ~CLK_I;
  camtp_core u_dut (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .SFR_ADDR_I(SFR_ADDR_I),
    .SFR_WDATA_I(SFR_WDATA_I), .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I),
    .SFR_RDATA_O(SFR_RDATA_O), .OBJ_SEL_I(OBJ_SEL_I), .AUTO_INC_I(AUTO_INC_I),
    .PTR_LOAD_I(PTR_LOAD_I), .PTR_INDEX_I(PTR_INDEX_I), .RX_ID_I(RX_ID_I),
    .RX_RTR_I(RX_RTR_I), .RX_IDE_I(RX_IDE_I), .TAG_ID_I(TAG_ID_I), .TAG_RTR_I(TAG_RTR_I),
    .TAG_IDE_I(TAG_IDE_I), .OBJ_IS_RX_I(OBJ_IS_RX_I), .ACCEPT_HIT_O(ACCEPT_HIT_O));
  camtp_rx_node u_node (.clk_i(CLK_I), .step_i(step), .id_o(RX_ID_I), .rtr_o(RX_RTR_I),
    .ide_o(RX_IDE_I));
  // ------------------------------------------------------------
  // bus tasks and expectations
  // ------------------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_I) {SFR_ADDR_I, SFR_WDATA_I, SFR_WR_I} <= {a, d, 1'b1};
    @(posedge CLK_I) SFR_WR_I <= 0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK_I) {SFR_ADDR_I, SFR_RD_I} <= {a, 1'b1};
    @(posedge CLK_I) SFR_RD_I <= 0;
    #1 d = SFR_RDATA_O;
  endtask : rd
  // write then read back on the next cycle, no idle cycle between
  task wrrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge CLK_I) {SFR_ADDR_I, SFR_WDATA_I, SFR_WR_I} <= {a, d, 1'b1};
    @(posedge CLK_I) {SFR_WR_I, SFR_RD_I} <= 2'b01;
    @(posedge CLK_I) SFR_RD_I <= 0;
    #1 q = SFR_RDATA_O;
  endtask : wrrd
  task ld(input logic [2:0] i);
    @(posedge CLK_I) {PTR_INDEX_I, PTR_LOAD_I} <= {i, 1'b1};
    @(posedge CLK_I) PTR_LOAD_I <= 0;
  endtask : ld
  function automatic logic exp_hit();
    return OBJ_IS_RX_I && (((RX_ID_I ^ TAG_ID_I) & mk) == 0) &&
      (!m[3][2] || RX_RTR_I == TAG_RTR_I) && (!m[3][0] || RX_IDE_I == TAG_IDE_I);
  endfunction : exp_hit
  task test_done();
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    void'($urandom(28));
    repeat (16) @(posedge CLK_I);
    RESET_N_I <= 1;
    rd(ADDR_PRESCALE, v); chk(v, 8'h00);
    rd(8'h10, v); chk(v, 8'h00);
    for (int r = 0; r < 6; r++) begin
      foreach (m[i]) m[i] = r == 0 ? 8'hFF : r == 1 ? 8'h00 : 8'($urandom);
      m[3][1] = 0;
      foreach (m[i]) wr(ADDR_MASK_ONE + 8'(i), m[i]);
      mk = {m[0], m[1], m[2], m[3][7:3]};
      rd(ADDR_MASK_THREE, v); chk(v, m[2]);
      rd(ADDR_MASK_FOUR, v); chk(v, m[3]);
      rd(ADDR_MASK_ONE, v); chk(v, m[0]);
      rd(ADDR_MASK_TWO, v); chk(v, m[1]);
      for (int k = 0; k < 40; k++) begin
        @(posedge CLK_I) step <= 1;
        @(posedge CLK_I) step <= 0;
        // node fields settle one edge after the step pulse
        @(posedge CLK_I);
        b = $urandom % 40;
        TAG_ID_I <= RX_ID_I ^ (b < 29 ? 29'h1 << b : 29'h0);
        TAG_RTR_I <= RX_RTR_I ^ (b == 29);
        TAG_IDE_I <= RX_IDE_I ^ (b == 30);
        OBJ_IS_RX_I <= ($urandom % 5) != 0;
        @(posedge CLK_I) #1 chk({7'h00, ACCEPT_HIT_O}, {7'h00, exp_hit()});
      end
    end
    @(posedge CLK_I) AUTO_INC_I <= 1;
    for (int o = 0; o < 4; o++) begin
      OBJ_SEL_I <= 2'(o);
      ld(3'h6);
      for (int j = 0; j < 3; j++) wr(ADDR_MBOX_DATA, 8'(16 * j + o));
    end
    for (int o = 3; o >= 0; o--) begin
      @(posedge CLK_I) OBJ_SEL_I <= 2'(o);
      ld(3'h6);
      for (int j = 0; j < 3; j++) begin
        rd(ADDR_MBOX_DATA, v); chk(v, 8'(16 * j + o));
      end
    end
    @(posedge CLK_I) AUTO_INC_I <= 0;
    wrrd(ADDR_MBOX_DATA, 8'h5A, v); chk(v, 8'h5A);
    rd(ADDR_MBOX_DATA, v); chk(v, 8'h5A);
    repeat (3) begin
      t0 = 8'($urandom);
      wrrd(ADDR_PRESCALE, t0, v); chk(v, t0);
    end
    wr(ADDR_PRESCALE, 8'h03);
    // a count left above the new limit runs to FF and wraps first
    repeat (260) @(posedge CLK_I);
    rd(ADDR_TIMER_LOW, t0);
    repeat (78) @(posedge CLK_I);
    rd(ADDR_TIMER_LOW, v); chk(v - t0, 8'h14);
    // second reset in mid-run: timer and prescaler restart, masks keep content
    @(posedge CLK_I) RESET_N_I <= 0;
    repeat (4) @(posedge CLK_I);
    RESET_N_I <= 1;
    rd(ADDR_TIMER_LOW, v); chk(v, 8'h01);
    rd(ADDR_PRESCALE, v); chk(v, PRESCALE_RST);
    wr(ADDR_TIMER_HIGH, 8'hFF);
    rd(ADDR_TIMER_HIGH, v); chk(v, 8'h00);
    rd(ADDR_MASK_THREE, v); chk(v, m[2]);
    test_done();
  end
endmodule : can_accept_mask_msg_timer_presc_tb
`default_nettype wire
